// [core/rtcupd_top.sv]
`timescale 1ns/1ps
`include "rtcupd_defines.svh"

module rtcupd_top #(
  parameter int UPDATE_CYC = `RTCUPD_UPDATE_CYC
) (
  input  wire logic       i_clk,         // 100 MHz clock
  input  wire logic       i_reset,       // Synchronous reset, high
  input  wire logic [7:0] i_addr,        // Register address
  input  wire logic [7:0] i_wdata,       // Write data
  input  wire logic       i_wr,          // Write strobe
  input  wire logic       i_rd,          // Read strobe
  output logic      [7:0] o_rdata,       // Read data, cycle after i_rd
  output logic            o_write_update_flag,       // Write flag
  output logic            o_read_buffer_update_flag, // Read flag
  output logic            o_write_xfer_busy,         // Write copy busy
  output logic            o_read_xfer_busy,          // Read copy busy
  output logic            o_power_loss_restart_enable, // Feature on
  output logic      [1:0] o_power_loss_threshold,    // Threshold code
  output logic     [31:0] o_power_loss_threshold_ms  // Threshold in ms
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic sel_ctrl_w;
  wire logic sel_stat_w;
  wire logic sel_plr_w;
  wire logic wr_ctrl_w;
  wire logic wr_stat_w;
  wire logic wr_plr_w;
  wire logic rd_stat_w;

  assign sel_ctrl_w = (i_addr == `RTCUPD_OFS_UPD_CTRL);
  assign sel_stat_w = (i_addr == `RTCUPD_OFS_UPD_STATUS);
  assign sel_plr_w  = (i_addr == `RTCUPD_OFS_PLR_CTRL);
  assign wr_ctrl_w  = i_wr && sel_ctrl_w;
  assign wr_stat_w  = i_wr && sel_stat_w;
  assign wr_plr_w   = i_wr && sel_plr_w;
  assign rd_stat_w  = i_rd && sel_stat_w;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  logic                             fcor_q;
  logic                             plr_en_q;
  rtcupd_pkg::rtcupd_threshold_type thr_q;

  // Only physical bits are stored; reserved positions are dropped.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      fcor_q   <= `RTCUPD_RST_FCOR;
      plr_en_q <= `RTCUPD_RST_PLR_EN;
      thr_q    <= `RTCUPD_RST_THR;
    end else begin
      if (wr_ctrl_w) begin
        fcor_q <= i_wdata[`RTCUPD_BIT_FCOR];
      end
      if (wr_plr_w) begin
        plr_en_q <= i_wdata[`RTCUPD_BIT_PLR_EN];
        thr_q    <= i_wdata[`RTCUPD_BIT_THR_HI:`RTCUPD_BIT_THR_LO];
      end
    end
  end

  // ****************************************************************
  // Flag clear terms
  // ****************************************************************
  wire logic wur_w;
  wire logic rbur_w;
  wire logic clr_wuf_w;
  wire logic clr_rbuf_w;

  // Request bits are self-clearing strobes, so they read back zero.
  assign wur_w  = wr_ctrl_w && i_wdata[`RTCUPD_BIT_WUR];
  assign rbur_w = wr_ctrl_w && i_wdata[`RTCUPD_BIT_RBUR];
  // With clear-on-read the read clears; otherwise a written 0 clears.
  assign clr_wuf_w  = (fcor_q && rd_stat_w) ||
                      (!fcor_q && wr_stat_w &&
                       !i_wdata[`RTCUPD_BIT_WUF]);
  assign clr_rbuf_w = (fcor_q && rd_stat_w) ||
                      (!fcor_q && wr_stat_w &&
                       !i_wdata[`RTCUPD_BIT_RBUF]);

  // ****************************************************************
  // Transfer engines
  // ****************************************************************
  logic wuf_w;
  logic rbuf_w;
  logic wbusy_w;
  logic rbusy_w;

  // Completion lands UPDATE_CYC cycles after the request strobe.
  rtcupd_xfer #(
    .DELAY_CYC (32'(UPDATE_CYC)),
    .FLAG_RST  (`RTCUPD_RST_WUF)
  ) u_write_xfer (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_request (wur_w),
    .i_clear   (clr_wuf_w),
    .o_flag    (wuf_w),
    .o_busy    (wbusy_w)
  );

  rtcupd_xfer #(
    .DELAY_CYC (32'(UPDATE_CYC)),
    .FLAG_RST  (`RTCUPD_RST_RBUF)
  ) u_read_xfer (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .i_request (rbur_w),
    .i_clear   (clr_rbuf_w),
    .o_flag    (rbuf_w),
    .o_busy    (rbusy_w)
  );

  // ****************************************************************
  // Read mux
  // ****************************************************************
  wire logic [7:0] stat_val_w;
  wire logic [7:0] ctrl_val_w;
  wire logic [7:0] plr_val_w;
  wire logic [7:0] rd_mux_w;
  logic      [7:0] rdata_q;

  // Reserved positions return zero.
  assign stat_val_w = {6'h00, rbuf_w, wuf_w};
  assign ctrl_val_w = {5'h00, fcor_q, 2'h0};
  assign plr_val_w  = {plr_en_q, 3'h0, thr_q, 2'h0};
  assign rd_mux_w   = sel_stat_w ? stat_val_w :
                      sel_ctrl_w ? ctrl_val_w :
                      sel_plr_w  ? plr_val_w  : 8'h00;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= i_rd ? rd_mux_w : 8'h00;
    end
  end

  // ****************************************************************
  // Threshold decode
  // ****************************************************************
  logic [31:0] thr_ms_q;

  // Code n selects (n + 1) half-second steps: 500, 1000, 1500, 2000 ms.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      thr_ms_q <= 32'h0000_0000;
    end else begin
      thr_ms_q <= (32'(thr_q) + 32'h0000_0001) *
                  32'(`RTCUPD_THR_STEP_MS);
    end
  end

  assign o_rdata                     = rdata_q;
  assign o_write_update_flag         = wuf_w;
  assign o_read_buffer_update_flag   = rbuf_w;
  assign o_write_xfer_busy           = wbusy_w;
  assign o_read_xfer_busy            = rbusy_w;
  assign o_power_loss_restart_enable = plr_en_q;
  assign o_power_loss_threshold      = thr_q;
  assign o_power_loss_threshold_ms   = thr_ms_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking chk_cb @(posedge i_clk);
  endclocking

  default disable iff (i_reset);

  logic [31:0] wr_age_q;
  logic [31:0] rd_age_q;

  // Cycles since each engine took its request. The timing checks count on
  // their own so that a wrong engine counter cannot hide behind itself.
  always_ff @(posedge i_clk) begin
    if (i_reset || (wur_w && !wbusy_w)) begin
      wr_age_q <= 32'h0000_0000;
    end else if (wbusy_w) begin
      wr_age_q <= wr_age_q + 32'h0000_0001;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset || (rbur_w && !rbusy_w)) begin
      rd_age_q <= 32'h0000_0000;
    end else if (rbusy_w) begin
      rd_age_q <= rd_age_q + 32'h0000_0001;
    end
  end

  sequence s_write_req;
    wur_w && !wbusy_w;
  endsequence

  sequence s_read_req;
    rbur_w && !rbusy_w;
  endsequence

  // A code that has stood for two edges has settled its registered decode.
  sequence s_thr_held(logic [1:0] c);
    (!i_reset && thr_q == c) ##1 (thr_q == c);
  endsequence

  // Write-update flag.
  a_wuf_low_busy: assert property (
    s_write_req |=> !wuf_w)
    else $error("Write flag set while transfer pending.");

  a_wuf_busy_low: assert property (
    wbusy_w |-> !wuf_w)
    else $error("Write flag high during a transfer.");

  a_wuf_from_done: assert property (
    $rose(wuf_w) |-> $past(wbusy_w))
    else $error("Write flag rose without a transfer.");

  a_wuf_rise_time: assert property (
    $rose(wuf_w) |-> wr_age_q == 32'(UPDATE_CYC))
    else $error("Write flag rose at the wrong cycle.");

  a_wr_age_cap: assert property (
    wbusy_w |-> wr_age_q < 32'(UPDATE_CYC))
    else $error("Write transfer ran too long.");

  a_fcor_clear: assert property (
    fcor_q && rd_stat_w && !u_write_xfer.done_w |=> !wuf_w)
    else $error("Clear on read did not clear write flag.");

  a_manual_hold: assert property (
    wuf_w && !fcor_q && !wr_stat_w && !wur_w |=> wuf_w)
    else $error("Write flag dropped without a clear.");

  a_manual_clear: assert property (
    !fcor_q && wr_stat_w && !i_wdata[`RTCUPD_BIT_WUF] &&
    !u_write_xfer.done_w |=> !wuf_w)
    else $error("Written zero did not clear write flag.");

  // Read-buffer-update flag.
  a_rbuf_low_busy: assert property (
    s_read_req |=> !rbuf_w)
    else $error("Read flag set while copy pending.");

  a_rbuf_busy_low: assert property (
    rbusy_w |-> !rbuf_w)
    else $error("Read flag high during a copy.");

  a_rbuf_rise_time: assert property (
    $rose(rbuf_w) |-> rd_age_q == 32'(UPDATE_CYC))
    else $error("Read flag rose at the wrong cycle.");

  a_rd_age_cap: assert property (
    rbusy_w |-> rd_age_q < 32'(UPDATE_CYC))
    else $error("Read copy ran too long.");

  a_rbuf_cor_clear: assert property (
    fcor_q && rd_stat_w && !u_read_xfer.done_w |=> !rbuf_w)
    else $error("Clear on read did not clear read flag.");

  a_rbuf_hold: assert property (
    rbuf_w && !clr_rbuf_w && !rbur_w |=> rbuf_w)
    else $error("Read buffer flag dropped without a clear.");

  // Reserved positions and request bits read back zero.
  a_resv_zero: assert property (
    $past(i_rd && sel_plr_w) |-> o_rdata[6:4] == 3'h0 &&
    o_rdata[1:0] == 2'h0)
    else $error("Reserved bits read non-zero.");

  a_resv_stat: assert property (
    $past(rd_stat_w) |-> o_rdata[7:2] == 6'h00)
    else $error("Status reserved bits read non-zero.");

  a_resv_ctrl: assert property (
    $past(i_rd && sel_ctrl_w) |-> o_rdata[7:3] == 5'h00 &&
    o_rdata[1:0] == 2'h0)
    else $error("Control reserved bits read non-zero.");

  // Threshold decode, one check per code.
  a_thr_half: assert property (
    s_thr_held(2'h0) |-> thr_ms_q == 32'h0000_01F4)
    else $error("Threshold code 0 not 0.5 s.");

  a_thr_one: assert property (
    s_thr_held(2'h1) |-> thr_ms_q == 32'h0000_03E8)
    else $error("Threshold code 1 not 1.0 s.");

  a_thr_one_half: assert property (
    s_thr_held(2'h2) |-> thr_ms_q == 32'h0000_05DC)
    else $error("Threshold code 2 not 1.5 s.");

  a_thr_map: assert property (
    s_thr_held(2'h3) |-> thr_ms_q == 32'h0000_07D0)
    else $error("Threshold code 3 not 2.0 s.");

endmodule

// [pkg/rtcupd_defines.svh]
`ifndef RTCUPD_DEFINES_SVH
`define RTCUPD_DEFINES_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define RTCUPD_ADDR_W          8
`define RTCUPD_OFS_UPD_CTRL    8'h0_4
`define RTCUPD_OFS_UPD_STATUS  8'h0_5
`define RTCUPD_OFS_PLR_CTRL    8'h0_6

// ****************************************************************
// Field positions
// ****************************************************************
`define RTCUPD_BIT_WUF         0
`define RTCUPD_BIT_RBUF        1
`define RTCUPD_BIT_WUR         0
`define RTCUPD_BIT_RBUR        1
`define RTCUPD_BIT_FCOR        2
`define RTCUPD_BIT_PLR_EN      7
`define RTCUPD_BIT_THR_HI      3
`define RTCUPD_BIT_THR_LO      2

// ****************************************************************
// Reset values
// ****************************************************************
`define RTCUPD_RST_WUF         1'b0
`define RTCUPD_RST_RBUF        1'b1
`define RTCUPD_RST_FCOR        1'b0
`define RTCUPD_RST_PLR_EN      1'b0
`define RTCUPD_RST_THR         2'h0

// ****************************************************************
// Timing
// ****************************************************************
`define RTCUPD_CLK_MHZ         100
`define RTCUPD_UPDATE_MS       15
`define RTCUPD_UPDATE_CYC      (`RTCUPD_UPDATE_MS * `RTCUPD_CLK_MHZ * 1000)
`define RTCUPD_THR_STEP_MS     500
`define RTCUPD_CNT_W           32

`endif

// [pkg/rtcupd_pkg.sv]
package rtcupd_pkg;

  typedef enum logic [1:0] {
    RTCUPD_IDLE,
    RTCUPD_BUSY,
    RTCUPD_DONE
  } rtcupd_xfer_state_type;

  typedef logic [1:0] rtcupd_threshold_type;

endpackage

// [core/rtcupd_xfer.sv]
`timescale 1ns/1ps
`include "rtcupd_defines.svh"

// One buffer transfer engine: request starts a timed copy, flag reports it.
module rtcupd_xfer #(
  parameter logic [31:0] DELAY_CYC = 32'h0000_0001,
  parameter logic        FLAG_RST  = 1'b0
) (
  input  wire logic i_clk,       // System clock
  input  wire logic i_reset,     // Synchronous reset
  input  wire logic i_request,   // One-cycle request pulse
  input  wire logic i_clear,     // One-cycle flag clear pulse
  output logic      o_flag,      // Transfer done flag
  output logic      o_busy       // Transfer in progress
);

  rtcupd_pkg::rtcupd_xfer_state_type state_q;
  rtcupd_pkg::rtcupd_xfer_state_type state_d;
  logic [31:0] count_q;
  logic        flag_q;
  wire logic   done_w;

  assign done_w = (state_q == rtcupd_pkg::RTCUPD_BUSY) &&
                  (count_q == DELAY_CYC - 32'h0000_0001);
  assign o_flag = flag_q;
  assign o_busy = (state_q == rtcupd_pkg::RTCUPD_BUSY);

  always_comb begin
    state_d = state_q;
    case (state_q)
      rtcupd_pkg::RTCUPD_IDLE: begin
        if (i_request) begin
          state_d = rtcupd_pkg::RTCUPD_BUSY;
        end
      end
      rtcupd_pkg::RTCUPD_BUSY: begin
        if (done_w) begin
          state_d = rtcupd_pkg::RTCUPD_DONE;
        end
      end
      // A request in the completion cycle is taken, not silently lost.
      rtcupd_pkg::RTCUPD_DONE: begin
        if (i_request) begin
          state_d = rtcupd_pkg::RTCUPD_BUSY;
        end else begin
          state_d = rtcupd_pkg::RTCUPD_IDLE;
        end
      end
      default: begin
        state_d = rtcupd_pkg::RTCUPD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= rtcupd_pkg::RTCUPD_IDLE;
      count_q <= 32'h0000_0000;
    end else begin
      state_q <= state_d;
      count_q <= (state_q == rtcupd_pkg::RTCUPD_BUSY) ?
                 count_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // A new request drops the flag; completion raises it and beats a clear.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      flag_q <= FLAG_RST;
    end else if (done_w) begin
      flag_q <= 1'b1;
    end else if (i_request && state_q != rtcupd_pkg::RTCUPD_BUSY) begin
      flag_q <= 1'b0;
    end else if (i_clear) begin
      flag_q <= 1'b0;
    end
  end

endmodule

// [tb/rtcupd_top_tb_top.sv]
`timescale 1ns/1ps
`include "rtcupd_defines.svh"

// ****************************************************************
// Comparison helper
// ****************************************************************
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("Error t=%0t got %0h exp %0h", $time, (g), (e)); end end

module rtcupd_top_tb_top;
  // Short update count keeps the run small; expectations use it too.
  localparam int UC = 20;

  logic        i_clk   = 1'b0;
  logic        i_reset = 1'b1;
  logic [7:0]  i_addr  = 8'h0_0;
  logic [7:0]  i_wdata = 8'h0_0;
  logic        i_wr    = 1'b0;
  logic        i_rd    = 1'b0;
  logic [7:0]  o_rdata;
  logic        o_write_update_flag;
  logic        o_read_buffer_update_flag;
  logic        o_write_xfer_busy;
  logic        o_read_xfer_busy;
  logic        o_power_loss_restart_enable;
  logic [1:0]  o_power_loss_threshold;
  logic [31:0] o_power_loss_threshold_ms;
  int          fails       = 0;
  int          checks_done = 0;
  int          n;
  logic [7:0]  rd_v;
  logic        en;
  logic [1:0]  code;
  logic [7:0]  bad;

  rtcupd_top #(.UPDATE_CYC(UC)) dut (
    .i_clk                       (i_clk),
    .i_reset                     (i_reset),
    .i_addr                      (i_addr),
    .i_wdata                     (i_wdata),
    .i_wr                        (i_wr),
    .i_rd                        (i_rd),
    .o_rdata                     (o_rdata),
    .o_write_update_flag         (o_write_update_flag),
    .o_read_buffer_update_flag   (o_read_buffer_update_flag),
    .o_write_xfer_busy           (o_write_xfer_busy),
    .o_read_xfer_busy            (o_read_xfer_busy),
    .o_power_loss_restart_enable (o_power_loss_restart_enable),
    .o_power_loss_threshold      (o_power_loss_threshold),
    .o_power_loss_threshold_ms   (o_power_loss_threshold_ms)
  );

  always #5 i_clk = ~i_clk;

  // ****************************************************************
  // Bus tasks and expectations
  // ****************************************************************
  function automatic logic [31:0] thr_ms(input logic [1:0] c);
    return 32'h0000_01F4 * ({30'h0, c} + 32'h0000_0001);
  endfunction

  task automatic close_out();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  // Counts edges until both flags show the wanted pattern.
  task automatic wait_flags(input logic [1:0] m);
    n = 0;
    while ({o_read_buffer_update_flag, o_write_update_flag} !== m) begin
      @(posedge i_clk);
      #1;
      n++;
      if (n > 4 * UC) begin
        fails++;
        close_out();
      end
    end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    void'($urandom(40));
    repeat (3) @(posedge i_clk);
    i_reset <= 1'b0;
    #1;
    `CHK(o_write_update_flag, 1'b0)
    `CHK(o_read_buffer_update_flag, 1'b1)
    `CHK({o_read_xfer_busy, o_write_xfer_busy}, 2'b00)
    rd(`RTCUPD_OFS_UPD_STATUS, rd_v);
    `CHK(rd_v, 8'h0_2)
    rd(`RTCUPD_OFS_PLR_CTRL, rd_v);
    `CHK(rd_v, 8'h0_0)
    // Write request with clear-on-read off.
    wr(`RTCUPD_OFS_UPD_CTRL, 8'h0_1);
    `CHK(o_write_xfer_busy, 1'b1)
    `CHK(o_write_update_flag, 1'b0)
    wait_flags(2'b11);
    `CHK(n, UC)
    `CHK(o_write_xfer_busy, 1'b0)
    rd(`RTCUPD_OFS_UPD_STATUS, rd_v);
    `CHK(rd_v, 8'h0_3)
    `CHK(o_write_update_flag, 1'b1)
    // Writing 0 clears only the bit written as 0.
    wr(`RTCUPD_OFS_UPD_STATUS, 8'h0_1);
    `CHK(o_read_buffer_update_flag, 1'b0)
    `CHK(o_write_update_flag, 1'b1)
    // Both requests with clear-on-read on; write flag is set here.
    wr(`RTCUPD_OFS_UPD_CTRL, 8'h0_7);
    `CHK({o_read_xfer_busy, o_write_xfer_busy}, 2'b11)
    wait_flags(2'b11);
    `CHK(n, UC)
    rd(`RTCUPD_OFS_UPD_STATUS, rd_v);
    `CHK(rd_v, 8'h0_3)
    `CHK({o_read_buffer_update_flag, o_write_update_flag}, 2'b00)
    // Clear-on-read off: a status read keeps the flag, a written 0 clears.
    wr(`RTCUPD_OFS_UPD_CTRL, 8'h0_1);
    wait_flags(2'b01);
    `CHK(n, UC)
    rd(`RTCUPD_OFS_UPD_STATUS, rd_v);
    `CHK(rd_v, 8'h0_1)
    wr(`RTCUPD_OFS_UPD_STATUS, 8'h0_2);
    `CHK({o_read_buffer_update_flag, o_write_update_flag}, 2'b00)
    // Every threshold code, with a random enable; reserved bits kept 0.
    for (int c = 0; c < 4; c++) begin
      code = c[1:0];
      en   = 1'($urandom);
      wr(`RTCUPD_OFS_PLR_CTRL, {en, 3'h0, code, 2'h0});
      @(posedge i_clk);
      #1;
      `CHK(o_power_loss_restart_enable, en)
      `CHK(o_power_loss_threshold, code)
      `CHK(o_power_loss_threshold_ms, thr_ms(code))
      rd(`RTCUPD_OFS_PLR_CTRL, rd_v);
      `CHK(rd_v, {en, 3'h0, code, 2'h0})
    end
    // Unmapped read returns zero.
    bad = 8'h1_0 + 8'($urandom % 224);
    rd(bad, rd_v);
    `CHK(rd_v, 8'h0_0)
    close_out();
  end
endmodule
